// ==== dcfifo_top.sv ====
/*
  dual-clock 8-bit fifo with full, almost-full, almost-empty and empty flags.
  assumes free-running write and read clocks, active-low enables from
  producer and consumer logic, and an asynchronous active-low reset pin.
*/
`timescale 1ns/10ps
`default_nettype none

// Operation
// RULE_01: full flag low at depth; writes blocked
// RULE_02: full and almost-full change on write clock
// RULE_03: empty and almost-empty change on read clock
// RULE_04: empty low when pointers equal; reads blocked
// RULE_05: almost-full low at depth minus seven
// RULE_06: almost-empty high from eight words stored
// RULE_07: flag encoding follows occupancy table
// RULE_08: outputs zero after reset, off when disabled
// RULE_09: reset works with clocks running
// RULE_10: full update may slip one write edge
// RULE_11: empty update may slip one read edge
// RULE_12: almost-full may slip one write edge
// RULE_13: almost-empty may slip one read edge
// RULE_14: first word latency bounded at empty
// RULE_15: width expansion combines endpoint flags externally
// RULE_16: depth expansion alternates devices externally
// RULE_17: reset clears pointers, sets flag levels
// RULE_18: write enable ignored while full
// RULE_19: read enable ignored while empty
// RULE_20: output register cleared during reset
// RULE_21: depth parameter, thresholds seven from ends
module dcfifo_top
  import dcfifo_pkg::*;
#(
  parameter int DEPTH = DCF_DEPTH_DEF // RULE_21
) (
  // write side
  input  wire logic                  wclk_i,
  input  wire logic                  write_en_n_i,
  input  wire logic [DCF_DATA_W-1:0] data_in_i,
  output var  logic                  full_flag_n_o,
  output var  logic                  almost_full_n_o,
  // read side
  input  wire logic                  clk_i,
  input  wire logic                  read_en_n_i,
  input  wire logic                  out_en_n_i,
  output var  logic [DCF_DATA_W-1:0] data_out_o,
  output var  logic                  data_out_oe_o,
  output var  logic                  empty_flag_n_o,
  output var  logic                  almost_empty_n_o,
  // reset
  input  wire logic                  arst_n_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] AF_LVL  = PW'(DEPTH - DCF_PART_MARGIN); // RULE_05 RULE_21
  localparam logic [PW-1:0] AE_LVL  = PW'(DCF_PART_MARGIN + 1);     // RULE_06 RULE_21

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--)
    begin
      b[i] = g[i] ^ b[i+1];
    end
    return b;
  endfunction

  // words held, from a write count and a read count
  function automatic logic [PW-1:0] fill_level(input logic [PW-1:0] wbin,
                                               input logic [PW-1:0] rbin);
    return wbin - rbin;
  endfunction

  // next pointer: one step on an accepted access
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p, input logic go);
    return go ? p + PW'(1) : p;
  endfunction

  // reset release per domain; assertion is asynchronous, clocks may run (RULE_09)
  logic [1:0] wrst_reg;
  logic [1:0] wrst_next;
  logic [1:0] rrst_reg;
  logic [1:0] rrst_next;
  logic       wrst_n;
  logic       rrst_n;

  // ones shift in behind the released pin
  always_comb
  begin
    wrst_next = {wrst_reg[0], 1'h1};
    rrst_next = {rrst_reg[0], 1'h1};
  end

  always_ff @(posedge wclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wrst_reg <= 2'h0; // RULE_09
    else
      wrst_reg <= wrst_next;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rrst_reg <= 2'h0; // RULE_09
    else
      rrst_reg <= rrst_next;
  end

  assign wrst_n = wrst_reg[1];
  assign rrst_n = rrst_reg[1];

  // storage
  logic [DCF_DATA_W-1:0] mem [DEPTH];

  // write domain
  logic [PW-1:0]   wptr_reg;
  logic [PW-1:0]   wptr_next;
  logic [PW-1:0]   wgray_reg;
  logic [PW-1:0]   wgray_next;
  logic [PW-1:0]   rgray_w1_reg;
  logic [PW-1:0]   rgray_w2_reg;
  logic [PW-1:0]   wcount;
  logic            wen_s1_reg;
  logic            wen_s2_reg;
  logic [DCF_DATA_W-1:0] din_s1_reg;
  logic [DCF_DATA_W-1:0] din_s2_reg;
  logic            wr_do;
  dcf_wflags_s     wflags_reg;
  dcf_wflags_s     wflags_next;

  // read domain
  logic [PW-1:0]   rptr_reg;
  logic [PW-1:0]   rptr_next;
  logic [PW-1:0]   rgray_reg;
  logic [PW-1:0]   rgray_next;
  logic [PW-1:0]   wgray_r1_reg;
  logic [PW-1:0]   wgray_r2_reg;
  logic [PW-1:0]   rcount;
  logic            ren_s1_reg;
  logic            ren_s2_reg;
  logic            oe_s1_reg;
  logic            oe_s2_reg;
  logic            rd_do;
  logic            oe_next;
  logic [DCF_DATA_W-1:0] dout_reg;
  logic [DCF_DATA_W-1:0] dout_next;
  dcf_rflags_s     rflags_reg;
  dcf_rflags_s     rflags_next;

  // write-side synchronisers: enable, data and read pointer
  always_ff @(posedge wclk_i or negedge wrst_n)
  begin
    if (!wrst_n)
    begin
      rgray_w1_reg <= '0;
      rgray_w2_reg <= '0;
      wen_s1_reg   <= 1'h1;
      wen_s2_reg   <= 1'h1;
      din_s1_reg   <= DCF_DOUT_RST;
      din_s2_reg   <= DCF_DOUT_RST;
    end
    else
    begin
      rgray_w1_reg <= rgray_reg;
      rgray_w2_reg <= rgray_w1_reg;
      wen_s1_reg   <= write_en_n_i;
      wen_s2_reg   <= wen_s1_reg;
      din_s1_reg   <= data_in_i;
      din_s2_reg   <= din_s1_reg;
    end
  end

  // write pointer
  always_comb
  begin
    wr_do      = !wen_s2_reg && wflags_reg.full_flag_n; // RULE_18 RULE_01
    wptr_next  = ptr_step(wptr_reg, wr_do);
    wgray_next = bin2gray(wptr_next);
  end

  always_ff @(posedge wclk_i or negedge wrst_n)
  begin
    if (!wrst_n)
    begin
      wptr_reg  <= '0; // RULE_17
      wgray_reg <= '0;
    end
    else
    begin
      wptr_reg  <= wptr_next;
      wgray_reg <= wgray_next;
    end
  end

  // write-side flags; a stale read count only delays their release
  always_comb
  begin
    wcount = fill_level(wptr_next, gray2bin(rgray_w2_reg)); // RULE_10 RULE_12
    wflags_next.full_flag_n   = (wcount < DEPTH_P); // RULE_01 RULE_07
    wflags_next.almost_full_n = (wcount < AF_LVL);  // RULE_05 RULE_07
  end

  always_ff @(posedge wclk_i or negedge wrst_n)
  begin
    if (!wrst_n)
      wflags_reg <= '{full_flag_n: DCF_FULL_RST_N, almost_full_n: DCF_AFULL_RST_N}; // RULE_17
    else
      wflags_reg <= wflags_next; // RULE_02
  end

  always_ff @(posedge wclk_i)
  begin
    if (wr_do)
      mem[wptr_reg[AW-1:0]] <= din_s2_reg;
  end

  // read-side synchronisers: enables and write pointer
  always_ff @(posedge clk_i or negedge rrst_n)
  begin
    if (!rrst_n)
    begin
      wgray_r1_reg <= '0;
      wgray_r2_reg <= '0;
      ren_s1_reg   <= 1'h1;
      ren_s2_reg   <= 1'h1;
      oe_s1_reg    <= 1'h1;
      oe_s2_reg    <= 1'h1;
    end
    else
    begin
      wgray_r1_reg <= wgray_reg;
      wgray_r2_reg <= wgray_r1_reg;
      ren_s1_reg   <= read_en_n_i;
      ren_s2_reg   <= ren_s1_reg;
      oe_s1_reg    <= out_en_n_i;
      oe_s2_reg    <= oe_s1_reg;
    end
  end

  // read pointer
  always_comb
  begin
    rd_do      = !ren_s2_reg && rflags_reg.empty_flag_n; // RULE_19 RULE_04
    rptr_next  = ptr_step(rptr_reg, rd_do);
    rgray_next = bin2gray(rptr_next);
  end

  always_ff @(posedge clk_i or negedge rrst_n)
  begin
    if (!rrst_n)
    begin
      rptr_reg  <= '0; // RULE_17
      rgray_reg <= '0;
    end
    else
    begin
      rptr_reg  <= rptr_next;
      rgray_reg <= rgray_next;
    end
  end

  // read-side flags; a stale write count only delays their release
  always_comb
  begin
    rcount = fill_level(gray2bin(wgray_r2_reg), rptr_next); // RULE_11 RULE_13 RULE_14
    rflags_next.empty_flag_n   = (rcount != '0);     // RULE_04 RULE_07
    rflags_next.almost_empty_n = (rcount >= AE_LVL); // RULE_06 RULE_07
  end

  always_ff @(posedge clk_i or negedge rrst_n)
  begin
    if (!rrst_n)
      rflags_reg <= '{empty_flag_n: DCF_EMPTY_RST_N, almost_empty_n: DCF_AEMPTY_RST_N}; // RULE_17
    else
      rflags_reg <= rflags_next; // RULE_03
  end

  // output register and driver enable
  always_comb
  begin
    dout_next = rd_do ? mem[rptr_reg[AW-1:0]] : dout_reg; // RULE_19
    oe_next   = !oe_s2_reg; // RULE_08
  end

  always_ff @(posedge clk_i or negedge rrst_n)
  begin
    if (!rrst_n)
    begin
      dout_reg      <= DCF_DOUT_RST; // RULE_20
      data_out_oe_o <= 1'h0;
    end
    else
    begin
      dout_reg      <= dout_next;
      data_out_oe_o <= oe_next; // RULE_08
    end
  end

  // outputs straight from flip-flops
  assign full_flag_n_o    = wflags_reg.full_flag_n;
  assign almost_full_n_o  = wflags_reg.almost_full_n;
  assign empty_flag_n_o   = rflags_reg.empty_flag_n;
  assign almost_empty_n_o = rflags_reg.almost_empty_n;
  assign data_out_o       = dout_reg; // RULE_08

endmodule // dcfifo_top
`default_nettype wire

// ==== dcfifo_pkg.sv ====
/*
  package for the dual-clock status-flag fifo: widths, thresholds, reset values, carriers.
  assumes nothing of its surroundings.
*/
`default_nettype none
package dcfifo_pkg;
  localparam int          DCF_DATA_W      = 8;
  localparam int          DCF_DEPTH_DEF   = 64;
  localparam int          DCF_PART_MARGIN = 7;
  localparam logic [7:0]  DCF_DOUT_RST    = 8'h00;
  localparam logic        DCF_FULL_RST_N  = 1'h1;
  localparam logic        DCF_AFULL_RST_N = 1'h1;
  localparam logic        DCF_AEMPTY_RST_N = 1'h0;
  localparam logic        DCF_EMPTY_RST_N = 1'h0;
  localparam int          DCF_SYNC_STAGES = 2;

  // write-side flags
  typedef struct packed {
    logic full_flag_n;
    logic almost_full_n;
  } dcf_wflags_s;

  // read-side flags
  typedef struct packed {
    logic empty_flag_n;
    logic almost_empty_n;
  } dcf_rflags_s;
endpackage
`default_nettype wire

// ==== dcfifo_top_assertions.sv ====
/*
  port checker for the status-flag fifo, bound to dcfifo_top.
  assumes free-running clocks and an async active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module dcfifo_top_assertions
  import dcfifo_pkg::*;
(
  // write side
  input wire logic       wclk_i,
  input wire logic       full_flag_n_o,
  input wire logic       almost_full_n_o,
  // read side
  input wire logic       clk_i,
  input wire logic       read_en_n_i,
  input wire logic       out_en_n_i,
  input wire logic [7:0] data_out_o,
  input wire logic       data_out_oe_o,
  input wire logic       empty_flag_n_o,
  input wire logic       almost_empty_n_o,
  input wire logic       arst_n_i
);
  sequence s_oe_on;
    !out_en_n_i [*8];
  endsequence
  sequence s_oe_off;
    out_en_n_i [*8];
  endsequence
  a_wr_reset: assert property (@(posedge wclk_i) !arst_n_i [*2] |-> full_flag_n_o && almost_full_n_o)
    else $error("write flags not reset");
  a_rd_reset: assert property (@(posedge clk_i) !arst_n_i [*2] |-> data_out_o == DCF_DOUT_RST
    && !data_out_oe_o && !empty_flag_n_o && !almost_empty_n_o) else $error("read side not reset");
  a_full_af: assert property (@(posedge wclk_i) disable iff (!arst_n_i)
    !full_flag_n_o |-> !almost_full_n_o) else $error("full without almost-full");
  a_empty_ae: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !empty_flag_n_o |-> !almost_empty_n_o) else $error("empty without almost-empty");
  a_full_order: assert property (@(posedge wclk_i) disable iff (!arst_n_i)
    $fell(full_flag_n_o) |-> !$past(almost_full_n_o)) else $error("full before almost-full");
  a_oe_on: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_oe_on |-> data_out_oe_o) else $error("outputs not driven");
  a_oe_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_oe_off |-> !data_out_oe_o) else $error("outputs not released");
  a_dout_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $changed(data_out_o) |-> $past(empty_flag_n_o)) else $error("read while empty");
  a_empty_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(empty_flag_n_o) |-> !$past(read_en_n_i, 2) || !$past(read_en_n_i, 3)
    || !$past(read_en_n_i, 4)) else $error("empty without read");
endmodule // dcfifo_top_assertions
bind dcfifo_top dcfifo_top_assertions dcfifo_top_assertions_i (.*);
`default_nettype wire

// ==== dcf_producer.sv ====
/*
  producer model: turns bench requests into write enable and data.
  assumes requests change on write-clock edges.
*/
`timescale 1ns/10ps
`default_nettype none
module dcf_producer (
  // requests
  input  wire logic       wclk_i,
  input  wire logic       req_i,
  input  wire logic [7:0] d_i,
  // fifo pins
  output var  logic       write_en_n_o,
  output var  logic [7:0] data_in_o
);
  // idle data toggles so no stale word looks valid
  always_ff @(posedge wclk_i)
  begin
    write_en_n_o <= !req_i;
    data_in_o    <= req_i ? d_i : ~data_in_o;
  end
endmodule // dcf_producer
`default_nettype wire

// ==== test_dcfifo_top.sv ====
/*
  testbench: fill past full, drain past empty, reset while running.
  assumes dcfifo_top and dcf_producer.
*/
`timescale 1ns/10ps
`default_nettype none
module test_dcfifo_top;
  localparam int D = 64;
  logic       clk, wclk, rst_n, req, ren_n, oe_n, wen_n, ff, af, ae, ef, oe;
  logic [7:0] din, d, dout, last, v, q[$];
  int         n_fail, n_compared, cyc;
  dcfifo_top #(.DEPTH(D)) dcfifo_top_i (.wclk_i(wclk), .write_en_n_i(wen_n), .data_in_i(din),
    .full_flag_n_o(ff), .almost_full_n_o(af), .clk_i(clk), .read_en_n_i(ren_n),
    .out_en_n_i(oe_n), .data_out_o(dout), .data_out_oe_o(oe), .empty_flag_n_o(ef),
    .almost_empty_n_o(ae), .arst_n_i(rst_n));
  dcf_producer dcf_producer_i (.wclk_i(wclk), .req_i(req), .d_i(d), .write_en_n_o(wen_n),
    .data_in_o(din));
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    wclk = 0;
    #2.3;
    forever #7 wclk = ~wclk;
  end
  // expected {full, almost-full, almost-empty, empty}
  function automatic logic [7:0] fl(int n);
    return {4'h0, n != D, n < D - 7, n > 7, n != 0};
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (n_fail == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] x);
    @(posedge wclk);
    req <= 1'b1;
    d <= x;
    @(posedge wclk);
    req <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task automatic rd(logic o);
    @(posedge clk);
    ren_n <= 1'b0;
    oe_n <= o;
    @(posedge clk);
    ren_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
  task automatic reset;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk({4'h0, ff, af, ae, ef}, fl(0));
    chk(dout, 8'h00);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_fail++;
      close_out();
    end
  end
  initial
  begin
    {rst_n, req, d, oe_n, cyc, n_fail, n_compared, last} = '0;
    ren_n = 1'b1;
    void'($urandom(45037));
    @(posedge clk);
    reset();
    chk({7'h0, oe}, 8'h01);
    for (int n = 1; n <= D + 1; n++)
    begin
      v = 8'($urandom);
      wr(v);
      if (n <= D)
        q.push_back(v);
      chk({4'h0, ff, af, ae, ef}, fl(n > D ? D : n));
    end
    for (int n = D - 1; n >= -1; n--)
    begin
      rd(1'($urandom));
      if (q.size() > 0)
        last = q.pop_front();
      chk(dout, last);
      chk({7'h0, oe}, {7'h0, !oe_n});
      chk({4'h0, ff, af, ae, ef}, fl(n < 0 ? 0 : n));
    end
    wr(8'hA5);
    reset();
    wr(8'h5A);
    chk({4'h0, ff, af, ae, ef}, fl(1));
    rd(1'h0);
    chk(dout, 8'h5A);
    close_out();
  end
endmodule // test_dcfifo_top
`default_nettype wire
